// ---- hdl/pcu_pin_detect.sv ----
/*
 pin synchroniser and any-edge detector for a bank of pins.
 assumes pins are asynchronous to clk; output pulses last one cycle.
*/
`timescale 1ns/1ps
module pcu_pin_detect #(
    parameter int N = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pins
    input wire logic [N-1:0] pins,
    // detected changes
    pcu_chg_if.src chg
);
    import pcu_pkg::*;

    logic [N-1:0] meta;
    logic [N-1:0] sync;
    logic [N-1:0] prev;
    logic [N-1:0] next_change;

    // change = synced level differs from last sample, either direction
    always_comb begin
        next_change = sync ^ prev;
    end

    // two stages stand in for the asynchronous detector of the part
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            sync <= '0;
            prev <= '0;
        end else begin
            meta <= pins;
            sync <= meta;
            prev <= sync;
        end
    end

    assign chg.level = sync;
    assign chg.change = next_change;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    AST_EDGE_SEEN: assert property (
        $changed(pins[0]) ##1 $stable(pins[0]) |-> ##1 chg.change[0])
        else $error("pin 0 change not detected");
endmodule

// ---- hdl/pcu_top.sv ----
/*
 pin-change interrupt unit: 32 pins in four groups, masks, group
 enables, sticky group flags and one request line per group vector.
 assumes an AXI4-Lite master on clk and a processor that pulses
 vector_taken for one cycle when it enters a group's service routine.
*/
// Functional notes
// - group 1 active only with its enable bit 1 and global enable.
// - unmasked change on pins 8..15 is a group 1 cause, vector 1.
// - group 0 active only with its enable bit 0 and global enable.
// - unmasked change on pins 0..7 requests the group 0 vector.
// - change on pins 24..31 sets flag bit 3.
// - change on pins 16..23 sets flag bit 2.
// - change on pins 8..15 sets flag bit 1.
// - change on pins 0..7 sets flag bit 0.
// - flag, group enable and global enable together raise the vector.
// - entering a group's service routine clears its flag.
// - writing one clears a flag; writing zero leaves it.
// - pins 24..31 detect only with mask three bit and group 3 enable.
// - pins 16..23 detect only with mask two bit and group 2 enable.
// - pins 8..15 detect only with mask one bit and group 1 enable.
// - pins 0..7 detect only with mask zero bit and group 0 enable.
// - a pin with its mask bit clear never contributes.
// - group 3 active only with enable bit 3 and global enable.
// - group 2 active only with enable bit 2 and global enable.
// - all 32 pins are watched for change independent of software.
`timescale 1ns/1ps
module pcu_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pins
    input wire logic [pcu_pkg::PCU_NUM_PINS-1:0] change_source_pins,
    // processor vector interface
    input wire pcu_pkg::pcu_group_t vector_taken,
    output pcu_pkg::pcu_group_t vector_req,
    // axi4-lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire pcu_pkg::pcu_addr_t s_axi_awaddr,
    // axi4-lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire pcu_pkg::pcu_data_t s_axi_wdata,
    input wire pcu_pkg::pcu_strb_t s_axi_wstrb,
    // axi4-lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output pcu_pkg::pcu_resp_t s_axi_bresp,
    // axi4-lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire pcu_pkg::pcu_addr_t s_axi_araddr,
    // axi4-lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output pcu_pkg::pcu_data_t s_axi_rdata,
    output pcu_pkg::pcu_resp_t s_axi_rresp
);
    import pcu_pkg::*;

    pcu_chg_if #(.N(PCU_NUM_PINS)) u_chg_bus ();

    pcu_pin_detect #(.N(PCU_NUM_PINS)) u_detect (
        .clk(clk),
        .rst(rst),
        .pins(change_source_pins),
        .chg(u_chg_bus.src)
    );

    // register state
    pcu_byte_t mask [PCU_NUM_GROUPS];
    pcu_byte_t next_mask [PCU_NUM_GROUPS];
    pcu_group_t enables;
    pcu_group_t next_enables;
    pcu_group_t flags;
    pcu_group_t next_flags;
    logic gie;
    logic next_gie;
    pcu_group_t next_vector_req;
    pcu_group_t group_set;
    pcu_group_t w1c_clear;

    // bus state
    logic aw_have;
    logic next_aw_have;
    logic w_have;
    logic next_w_have;
    pcu_addr_t aw_addr;
    pcu_addr_t next_aw_addr;
    pcu_data_t w_data;
    pcu_data_t next_w_data;
    pcu_strb_t w_strb;
    pcu_strb_t next_w_strb;
    logic do_write;
    logic next_awready;
    logic next_wready;
    logic next_bvalid;
    pcu_resp_t next_bresp;
    logic next_arready;
    logic next_rvalid;
    pcu_data_t next_rdata;
    pcu_resp_t next_rresp;
    logic wr_mapped;

    // write channels: address and data are held apart and joined later,
    // so the master may present them in either order
    always_comb begin
        next_aw_have = aw_have;
        next_w_have = w_have;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        do_write = aw_have && w_have && !s_axi_bvalid;
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (do_write) begin
            next_aw_have = 1'b0;
            next_w_have = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = wr_mapped ? PCU_RESP_OKAY : PCU_RESP_SLVERR;
        end
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_have = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_have = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        next_awready = !next_aw_have;
        next_wready = !next_w_have;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= PCU_RESP_OKAY;
        end else begin
            aw_have <= next_aw_have;
            w_have <= next_w_have;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
        end
    end

    // read channel: one read in flight, data one cycle after the address
    always_comb begin
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = PCU_RESP_OKAY;
            next_rdata = '0;
            case (s_axi_araddr)
                PCU_ADDR_MASK0: next_rdata[7:0] = mask[0];
                PCU_ADDR_MASK1: next_rdata[7:0] = mask[1];
                PCU_ADDR_MASK2: next_rdata[7:0] = mask[2];
                PCU_ADDR_MASK3: next_rdata[7:0] = mask[3];
                PCU_ADDR_ENABLES: next_rdata[3:0] = enables;
                PCU_ADDR_FLAGS: next_rdata[3:0] = flags;
                PCU_ADDR_CTRL: next_rdata[PCU_CTRL_GIE_BIT] = gie;
                default: next_rresp = PCU_RESP_SLVERR;
            endcase
        end
        next_arready = !next_rvalid;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= PCU_RESP_OKAY;
        end else begin
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

    // software registers; only byte lane 0 carries data
    always_comb begin
        next_mask = mask;
        next_enables = enables;
        next_gie = gie;
        w1c_clear = '0;
        wr_mapped = 1'b1;
        case (aw_addr)
            PCU_ADDR_MASK0,
            PCU_ADDR_MASK1,
            PCU_ADDR_MASK2,
            PCU_ADDR_MASK3,
            PCU_ADDR_ENABLES,
            PCU_ADDR_FLAGS,
            PCU_ADDR_CTRL: wr_mapped = 1'b1;
            default: wr_mapped = 1'b0;
        endcase
        if (do_write && w_strb[0]) begin
            case (aw_addr)
                PCU_ADDR_MASK0: next_mask[0] = w_data[7:0];
                PCU_ADDR_MASK1: next_mask[1] = w_data[7:0];
                PCU_ADDR_MASK2: next_mask[2] = w_data[7:0];
                PCU_ADDR_MASK3: next_mask[3] = w_data[7:0];
                PCU_ADDR_ENABLES: next_enables = w_data[3:0];
                PCU_ADDR_FLAGS: w1c_clear = w_data[3:0];
                PCU_ADDR_CTRL: next_gie = w_data[PCU_CTRL_GIE_BIT];
                default: next_gie = gie;
            endcase
        end
    end

    // group causes, flags and vector requests
    always_comb begin
        for (int g = 0; g < PCU_NUM_GROUPS; g++) begin
            // masked-off pins and disabled groups never set a flag
            group_set[g] = (|(u_chg_bus.change[g*PCU_GROUP_WIDTH +:
                PCU_GROUP_WIDTH] & mask[g])) && enables[g];
        end
        // set wins over a same-cycle clear so no change is lost
        next_flags = (flags & ~(w1c_clear | vector_taken)) | group_set;
        next_vector_req = flags & enables & {PCU_NUM_GROUPS{gie}};
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int g = 0; g < PCU_NUM_GROUPS; g++) begin
                mask[g] <= PCU_RST_MASK;
            end
            enables <= PCU_RST_ENABLES;
            flags <= PCU_RST_FLAGS;
            gie <= PCU_RST_GIE;
            vector_req <= '0;
        end else begin
            mask <= next_mask;
            enables <= next_enables;
            flags <= next_flags;
            gie <= next_gie;
            vector_req <= next_vector_req;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_cause(int g);
        enables[g] && (|(u_chg_bus.change[g*8 +: 8] & mask[g]));
    endsequence

    sequence s_flag_one(int g);
        do_write && w_strb[0] && aw_addr == PCU_ADDR_FLAGS && w_data[g];
    endsequence

    AST_G0_SET: assert property (s_cause(0) |=> flags[0])
        else $error("group 0 flag not set");
    AST_G1_SET: assert property (s_cause(1) |=> flags[1])
        else $error("group 1 flag not set");
    AST_G2_SET: assert property (s_cause(2) |=> flags[2])
        else $error("group 2 flag not set");
    AST_G3_SET: assert property (s_cause(3) |=> flags[3])
        else $error("group 3 flag not set");

    AST_G0_NEEDS_ENABLE: assert property (
        $rose(flags[0]) |-> $past(enables[0] &&
            (|(u_chg_bus.change[7:0] & mask[0]))))
        else $error("group 0 flag set without masked enabled change");
    AST_G1_NEEDS_ENABLE: assert property (
        $rose(flags[1]) |-> $past(enables[1] &&
            (|(u_chg_bus.change[15:8] & mask[1]))))
        else $error("group 1 flag set without masked enabled change");
    AST_G2_NEEDS_ENABLE: assert property (
        $rose(flags[2]) |-> $past(enables[2] &&
            (|(u_chg_bus.change[23:16] & mask[2]))))
        else $error("group 2 flag set without masked enabled change");
    AST_G3_NEEDS_ENABLE: assert property (
        $rose(flags[3]) |-> $past(enables[3] &&
            (|(u_chg_bus.change[31:24] & mask[3]))))
        else $error("group 3 flag set without masked enabled change");
    AST_MASKED_SILENT: assert property (
        !flags[1] && mask[1] == 8'h00 |=> !flags[1])
        else $error("masked pins raised group 1 flag");

    AST_W1C: assert property (
        s_flag_one(2) && !group_set[2] |=> !flags[2])
        else $error("write one did not clear group 2 flag");
    AST_W0_KEEPS: assert property (
        do_write && aw_addr == PCU_ADDR_FLAGS && !w_data[1] && flags[1]
            && !vector_taken[1] |=> flags[1])
        else $error("write zero cleared group 1 flag");
    AST_ACK_CLEARS: assert property (
        vector_taken[3] && !group_set[3] |=> !flags[3])
        else $error("service entry did not clear group 3 flag");

    AST_VEC0_GATED: assert property (
        vector_req[0] |-> $past(flags[0] && enables[0] && gie))
        else $error("group 0 vector without enables");
    AST_VEC1_GATED: assert property (
        vector_req[1] |-> $past(flags[1] && enables[1] && gie))
        else $error("group 1 vector without enables");
    AST_VEC2_GATED: assert property (
        vector_req[2] |-> $past(flags[2] && enables[2] && gie))
        else $error("group 2 vector without enables");
    AST_VEC3_GATED: assert property (
        vector_req[3] |-> $past(flags[3] && enables[3] && gie))
        else $error("group 3 vector without enables");
    AST_VEC_FIRES: assert property (
        flags[1] && enables[1] && gie |=> vector_req[1])
        else $error("group 1 vector not raised");
    AST_CAUSE_TO_VEC0: assert property (
        s_cause(0) ##1 (enables[0] && gie) |=> vector_req[0])
        else $error("group 0 change did not reach its vector");
    AST_CAUSE_TO_VEC1: assert property (
        s_cause(1) ##1 (enables[1] && gie) |=> vector_req[1])
        else $error("group 1 change did not reach its vector");
    AST_CHANGE_IS_EDGE: assert property (
        u_chg_bus.change[8] |->
            u_chg_bus.level[8] != $past(u_chg_bus.level[8]))
        else $error("group 1 change pulse without a level edge");
endmodule

// ---- inc/pcu_chg_if.sv ----
/*
 carrier between the pin detector and the interrupt core.
 assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface pcu_chg_if #(parameter int N = 32);
    logic [N-1:0] level;
    logic [N-1:0] change;
    modport src (output level, output change);
    modport dst (input level, input change);
endinterface

// ---- inc/pcu_pkg.sv ----
/*
 pin-change interrupt unit: shared constants, register map and types.
 assumes registers sit on a 32-bit AXI4-Lite bus, one aligned word each,
 byte address four times the register index.
*/
package pcu_pkg;
    localparam int PCU_NUM_GROUPS = 4;
    localparam int PCU_GROUP_WIDTH = 8;
    localparam int PCU_NUM_PINS = 32;
    localparam int PCU_SYNC_STAGES = 2;
    localparam int PCU_ADDR_W = 12;

    typedef logic [PCU_ADDR_W-1:0] pcu_addr_t;
    typedef logic [31:0] pcu_data_t;
    typedef logic [3:0] pcu_strb_t;
    typedef logic [1:0] pcu_resp_t;
    typedef logic [PCU_GROUP_WIDTH-1:0] pcu_byte_t;
    typedef logic [PCU_NUM_GROUPS-1:0] pcu_group_t;

    // register indices
    localparam logic [7:0] PCU_IDX_MASK0 = 8'h6b;
    localparam logic [7:0] PCU_IDX_MASK1 = 8'h6c;
    localparam logic [7:0] PCU_IDX_MASK2 = 8'h6d;
    localparam logic [7:0] PCU_IDX_MASK3 = 8'h73;
    localparam logic [7:0] PCU_IDX_ENABLES = 8'h68;
    localparam logic [7:0] PCU_IDX_FLAGS = 8'h70;
    localparam logic [7:0] PCU_IDX_CTRL = 8'h71;

    // byte addresses
    localparam pcu_addr_t PCU_ADDR_MASK0 = {2'h0, PCU_IDX_MASK0, 2'h0};
    localparam pcu_addr_t PCU_ADDR_MASK1 = {2'h0, PCU_IDX_MASK1, 2'h0};
    localparam pcu_addr_t PCU_ADDR_MASK2 = {2'h0, PCU_IDX_MASK2, 2'h0};
    localparam pcu_addr_t PCU_ADDR_MASK3 = {2'h0, PCU_IDX_MASK3, 2'h0};
    localparam pcu_addr_t PCU_ADDR_ENABLES = {2'h0, PCU_IDX_ENABLES, 2'h0};
    localparam pcu_addr_t PCU_ADDR_FLAGS = {2'h0, PCU_IDX_FLAGS, 2'h0};
    localparam pcu_addr_t PCU_ADDR_CTRL = {2'h0, PCU_IDX_CTRL, 2'h0};

    // fields
    localparam int PCU_CTRL_GIE_BIT = 0;

    // values after reset
    localparam pcu_byte_t PCU_RST_MASK = 8'h00;
    localparam pcu_group_t PCU_RST_ENABLES = 4'h0;
    localparam pcu_group_t PCU_RST_FLAGS = 4'h0;
    localparam logic PCU_RST_GIE = 1'h0;

    localparam pcu_resp_t PCU_RESP_OKAY = 2'h0;
    localparam pcu_resp_t PCU_RESP_SLVERR = 2'h2;
endpackage

// ---- testbench/pcu_pin_src.sv ----
/*
 far-side model: external drivers on the 32 change source pins.
 assumes the bench pulses flip for one clock for each requested toggle.
*/
`timescale 1ns/1ps
module pcu_pin_src #(
    parameter int SKEW_NS = 3
) (
    // clock
    input wire logic clk,
    // toggle request from the bench
    input wire logic [31:0] flip,
    // driven pin levels
    output logic [31:0] pins
);
    // pins move well off the edge, as an unrelated source would
    initial pins = 32'h00000000;
    always @(posedge clk) begin
        if (flip != 32'h00000000) begin
            pins <= #SKEW_NS pins ^ flip;
        end
    end
endmodule

// ---- testbench/pin_change_interrupt_unit_tb_top.sv ----
/*
 self-checking bench for the pin-change unit: axi4-lite master tasks,
 a register and flag model, random register, pin and clear traffic.
 assumes pcu_top and pcu_pin_src are compiled before it.
*/
`timescale 1ns/1ps
module pin_change_interrupt_unit_tb_top;
    import pcu_pkg::*;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [31:0] flip = 32'h0;
    logic [31:0] pins;
    pcu_group_t vtk = 4'h0;
    pcu_group_t vector_req;
    logic awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
    logic awr, wr, bv, arr, rv;
    pcu_addr_t awa = 12'h0, ara = 12'h0;
    pcu_data_t wd = 32'h0, rd;
    pcu_strb_t ws = 4'h0;
    pcu_resp_t bre, rre;
    int err_total = 0, n_compared = 0, cyc = 0;
    int seed = 32'h2f3fc88f;
    logic [7:0] msk [4];
    pcu_group_t en, flg;
    logic gie;
    pcu_addr_t maddr [4] = '{PCU_ADDR_MASK0, PCU_ADDR_MASK1,
        PCU_ADDR_MASK2, PCU_ADDR_MASK3};

    always #5 clk = ~clk;

    pcu_pin_src i_src (.clk(clk), .flip(flip), .pins(pins));
    pcu_top i_dut (.clk(clk), .rst(rst), .change_source_pins(pins),
        .vector_taken(vtk), .vector_req(vector_req),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_bresp(bre), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .s_axi_rdata(rd), .s_axi_rresp(rre));

    task automatic results();
        if (err_total == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // generous ceiling: the sequence needs well under half of it
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total = err_total + 1;
            results();
        end
    end

    task automatic cmp_dat(string nm, pcu_data_t e, pcu_data_t g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmp_rsp(string nm, pcu_resp_t e, pcu_resp_t g);
        cmp_dat(nm, {30'h0, e}, {30'h0, g});
    endtask

    task automatic cmp_grp(string nm, pcu_group_t e, pcu_group_t g);
        cmp_dat(nm, {28'h0, e}, {28'h0, g});
    endtask

    function automatic bit mapped(pcu_addr_t a);
        return a inside {PCU_ADDR_MASK0, PCU_ADDR_MASK1, PCU_ADDR_MASK2,
            PCU_ADDR_MASK3, PCU_ADDR_ENABLES, PCU_ADDR_FLAGS, PCU_ADDR_CTRL};
    endfunction

    function automatic pcu_resp_t exp_rsp(pcu_addr_t a);
        return mapped(a) ? PCU_RESP_OKAY : PCU_RESP_SLVERR;
    endfunction

    function automatic pcu_data_t model_rd(pcu_addr_t a);
        pcu_data_t d;
        d = 32'h0;
        for (int i = 0; i < 4; i++) if (a == maddr[i]) d = {24'h0, msk[i]};
        if (a == PCU_ADDR_ENABLES) d = {28'h0, en};
        if (a == PCU_ADDR_FLAGS) d = {28'h0, flg};
        if (a == PCU_ADDR_CTRL) d = {31'h0, gie};
        return d;
    endfunction

    task automatic put(pcu_addr_t a, pcu_data_t d, pcu_strb_t s);
        bit ta, tw;
        ta = 0;
        tw = 0;
        awv <= 1'h1;
        awa <= a;
        wv <= 1'h1;
        wd <= d;
        ws <= s;
        while (!(ta && tw)) begin
            @(posedge clk);
            if (!ta && awr === 1'h1) begin
                ta = 1;
                awv <= 1'h0;
            end
            if (!tw && wr === 1'h1) begin
                tw = 1;
                wv <= 1'h0;
            end
        end
        // a slow master leaves the response waiting now and then
        repeat ($unsigned($random(seed)) % 3) @(posedge clk);
        br <= 1'h1;
        do @(posedge clk); while (bv !== 1'h1);
        br <= 1'h0;
        cmp_rsp("bresp", exp_rsp(a), bre);
        if (s[0]) begin
            for (int i = 0; i < 4; i++) if (a == maddr[i]) msk[i] = d[7:0];
            if (a == PCU_ADDR_ENABLES) en = d[3:0];
            if (a == PCU_ADDR_FLAGS) flg = flg & ~d[3:0];
            if (a == PCU_ADDR_CTRL) gie = d[PCU_CTRL_GIE_BIT];
        end
        @(posedge clk);
    endtask

    task automatic get(pcu_addr_t a);
        arv <= 1'h1;
        ara <= a;
        do @(posedge clk); while (arr !== 1'h1);
        arv <= 1'h0;
        repeat ($unsigned($random(seed)) % 3) @(posedge clk);
        rr <= 1'h1;
        do @(posedge clk); while (rv !== 1'h1);
        rr <= 1'h0;
        cmp_dat("rdata", model_rd(a), rd);
        cmp_rsp("rresp", exp_rsp(a), rre);
        @(posedge clk);
    endtask

    task automatic do_reset();
        rst <= 1'h1;
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        foreach (msk[i]) msk[i] = 8'h00;
        en = 4'h0;
        flg = 4'h0;
        gie = 1'h0;
        // let the synchronisers refill while every group is still disabled
        repeat (6) @(posedge clk);
    endtask

    task automatic toggle(logic [31:0] f);
        flip <= f;
        @(posedge clk);
        flip <= 32'h0;
        repeat (6) @(posedge clk);
        for (int i = 0; i < 32; i++)
            if (f[i] && msk[i/8][i%8] && en[i/8]) flg[i/8] = 1'h1;
    endtask

    task automatic take(pcu_group_t v);
        vtk <= v;
        @(posedge clk);
        vtk <= 4'h0;
        flg = flg & ~v;
    endtask

    task automatic check();
        repeat (3) @(posedge clk);
        @(negedge clk);
        cmp_grp("vector_req", flg & en & {4{gie}}, vector_req);
        @(posedge clk);
        get(PCU_ADDR_FLAGS);
    endtask

    initial begin
        int op;
        do_reset();
        foreach (maddr[i]) get(maddr[i]);
        get(PCU_ADDR_ENABLES);
        get(PCU_ADDR_CTRL);
        get(12'h004);
        put(12'h004, 32'hffffffff, 4'hf);
        put(12'h1ad, 32'hffffffff, 4'hf);
        put(PCU_ADDR_MASK0, 32'h000000ff, 4'he);
        get(PCU_ADDR_MASK0);
        for (int n = 0; n < 400; n++) begin
            op = $unsigned($random(seed)) % 6;
            case (op)
                0: put(maddr[$unsigned($random(seed)) % 4], $random(seed),
                    4'hf);
                1: put(PCU_ADDR_ENABLES, $random(seed), 4'hf);
                2: put(PCU_ADDR_CTRL, $random(seed), 4'hf);
                3: toggle($random(seed) & $random(seed));
                4: put(PCU_ADDR_FLAGS, $random(seed), 4'hf);
                default: take(pcu_group_t'($random(seed)));
            endcase
            check();
            if (n == 200) do_reset();
        end
        results();
    end
endmodule
